//--- motor_start_profile_sequencer.sv
// start profile sequencer: soft start ramp, current limit hold, kickstart, dual ramp
// assumes all inputs synchronous to clk; settings are level inputs held by software
//
// Contract
// - starting-mode setting selects soft start ramp or current limit hold, with ramp, initial and kick settings
// - soft start raises voltage from initial level to full over 0..30 s
// - soft start ramp begins at initial level, 0..90 percent
// - kickstart applies a boost for 0..2.0 s at 0..90 percent level
// - full speed detected during soft start ends ramp and gives full voltage
// - current limit holds reduced level for ramp time, then full voltage
// - current limit level adjustable in percent of full load current, up to 600
// - full speed detected during current limit hold gives full voltage at once
// - dual ramp holds two profiles of start mode, ramp time, initial level
// - dual ramp samples contact input at start: low first profile, high second
// - settings changed while running take effect at the next start only
`timescale 1ns/1ps
module motor_start_profile_sequencer
  import motor_start_pkg::*;
#(
  parameter int TICK_CYCLES = motor_start_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // run control
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic full_speed,
  // dual ramp
  input wire logic dual_ramp_en,
  input wire logic dual_sel_in,
  // profile one
  input wire motor_start_pkg::start_mode_t mode1,
  input wire logic [motor_start_pkg::TENTHS_W-1:0] ramp1_tenths,
  input wire logic [motor_start_pkg::PCT_W-1:0] init1_pct,
  // profile two
  input wire motor_start_pkg::start_mode_t mode2,
  input wire logic [motor_start_pkg::TENTHS_W-1:0] ramp2_tenths,
  input wire logic [motor_start_pkg::PCT_W-1:0] init2_pct,
  // shared settings
  input wire logic [motor_start_pkg::CL_W-1:0] climit_pct,
  input wire logic [motor_start_pkg::TENTHS_W-1:0] kick_tenths,
  input wire logic [motor_start_pkg::PCT_W-1:0] kick_pct,
  // outputs to the power stage
  output motor_start_pkg::phase_t phase_q,
  output logic [motor_start_pkg::PCT_W-1:0] volt_pct_q,
  output logic climit_on_q,
  output logic [motor_start_pkg::CL_W-1:0] climit_out_q,
  output logic kick_on_q,
  output logic [motor_start_pkg::PCT_W-1:0] kick_out_q,
  output logic profile2_q,
  output logic at_full_q
);
  import motor_start_pkg::*;

  function automatic logic [CL_W-1:0] clamp(input logic [CL_W-1:0] v, input logic [CL_W-1:0] m);
    clamp = (v > m) ? m : v;
  endfunction

  function automatic logic [TICKS_W-1:0] to_ticks(input logic [TENTHS_W-1:0] t);
    to_ticks = TICKS_W'(t) * TICKS_W'(TICKS_PER_TENTH);
  endfunction

  // live settings, profile picked by the contact input
  wire sel_live = dual_ramp_en & dual_sel_in;
  wire start_mode_t mode_live = sel_live ? mode2 : mode1;
  wire [TENTHS_W-1:0] ramp_t_live = sel_live ? ramp2_tenths : ramp1_tenths;
  wire [PCT_W-1:0] init_raw = sel_live ? init2_pct : init1_pct;
  wire [TENTHS_W-1:0] ramp_c = TENTHS_W'(clamp(CL_W'(ramp_t_live), CL_W'(RAMP_MAX_TENTHS)));
  wire [TENTHS_W-1:0] kick_c = TENTHS_W'(clamp(CL_W'(kick_tenths), CL_W'(KICK_MAX_TENTHS)));
  wire [PCT_W-1:0] init_c = PCT_W'(clamp(CL_W'(init_raw), CL_W'(INIT_MAX_PCT)));
  wire [PCT_W-1:0] kpct_c = PCT_W'(clamp(CL_W'(kick_pct), CL_W'(KICK_MAX_PCT)));
  wire [CL_W-1:0] cl_c = clamp(climit_pct, CL_MAX_PCT);

  // settings frozen at start
  start_mode_t mode_q;
  logic [TICKS_W-1:0] ramp_ticks_q;
  logic [TICKS_W-1:0] kick_ticks_q;
  logic [PCT_W-1:0] init_q;
  logic [PCT_W-1:0] kpct_q;
  logic [CL_W-1:0] cl_q;
  logic [TICKS_W-1:0] elapsed_q;
  phase_t phase_d;
  logic tick;

  wire accept = (phase_q == ST_IDLE) && start_req && !stop_req;
  // snapshot taken only on accept, so running changes wait for the next start
  wire start_mode_t mode_d = accept ? mode_live : mode_q;
  wire [TICKS_W-1:0] ramp_ticks_d = accept ? to_ticks(ramp_c) : ramp_ticks_q;
  wire [TICKS_W-1:0] kick_ticks_d = accept ? to_ticks(kick_c) : kick_ticks_q;
  wire [PCT_W-1:0] init_d = accept ? init_c : init_q;
  wire [PCT_W-1:0] kpct_d = accept ? kpct_c : kpct_q;
  wire [CL_W-1:0] cl_d = accept ? cl_c : cl_q;

  wire [TICKS_W-1:0] elapsed_inc = elapsed_q + TICKS_W'(1);
  wire kick_last = tick && (elapsed_inc == kick_ticks_q);
  wire ramp_last = tick && (elapsed_inc == ramp_ticks_q);
  wire kick_none = (kick_ticks_d == '0);
  wire ramp_none = (ramp_ticks_d == '0);
  wire starting = (phase_q == ST_KICK) || (phase_q == ST_RAMP);

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      ST_IDLE: begin
        if (accept) begin
          // kick first, then the mode profile
          if (!kick_none) begin
            phase_d = ST_KICK;
          end else if (!ramp_none) begin
            phase_d = ST_RAMP;
          end else begin
            phase_d = ST_FULL;
          end
        end
      end
      ST_KICK: begin
        if (stop_req) begin
          phase_d = ST_IDLE;
        end else if (full_speed) begin
          phase_d = ST_FULL;
        end else if (kick_last) begin
          phase_d = ramp_none ? ST_FULL : ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (stop_req) begin
          phase_d = ST_IDLE;
        end else if (full_speed || ramp_last) begin
          phase_d = ST_FULL;
        end
      end
      ST_FULL: begin
        if (stop_req) begin
          phase_d = ST_IDLE;
        end
      end
    endcase
  end

  wire [TICKS_W-1:0] elapsed_d = (phase_d != phase_q) ? '0 : (tick ? elapsed_inc : elapsed_q);

  // linear soft start level: init + (full - init) * elapsed / ramp
  localparam int PROD_W = PCT_W + TICKS_W;
  wire [PROD_W-1:0] ramp_prod = PROD_W'(FULL_PCT - init_d) * PROD_W'(elapsed_d);
  wire [PROD_W-1:0] ramp_div = ramp_none ? PROD_W'(1) : PROD_W'(ramp_ticks_d);
  wire [PROD_W-1:0] ramp_quot = ramp_prod / ramp_div;
  wire [PCT_W-1:0] ramp_level = init_d + PCT_W'(ramp_quot);

  wire soft_d = (mode_d == MODE_SOFT);
  wire in_start_d = (phase_d == ST_KICK) || (phase_d == ST_RAMP);
  wire [PCT_W-1:0] volt_d =
    (phase_d == ST_FULL) ? FULL_PCT :
    (in_start_d && soft_d) ? ((phase_d == ST_RAMP) ? ramp_level : init_d) : '0;
  wire climit_on_d = in_start_d && !soft_d;
  wire kick_on_d = (phase_d == ST_KICK);

  start_tick_gen #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .restart(accept),
    .tick(tick)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= ST_IDLE;
      elapsed_q <= '0;
    end else begin
      phase_q <= phase_d;
      elapsed_q <= elapsed_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= MODE_SOFT;
      ramp_ticks_q <= '0;
      kick_ticks_q <= '0;
      init_q <= '0;
      kpct_q <= '0;
      cl_q <= '0;
      profile2_q <= 1'b0;
    end else if (accept) begin
      mode_q <= mode_d;
      ramp_ticks_q <= ramp_ticks_d;
      kick_ticks_q <= kick_ticks_d;
      init_q <= init_d;
      kpct_q <= kpct_d;
      cl_q <= cl_d;
      profile2_q <= sel_live;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      volt_pct_q <= '0;
      climit_on_q <= 1'b0;
      climit_out_q <= '0;
      kick_on_q <= 1'b0;
      kick_out_q <= '0;
      at_full_q <= 1'b0;
    end else begin
      volt_pct_q <= volt_d;
      climit_on_q <= climit_on_d;
      climit_out_q <= climit_on_d ? cl_d : '0;
      kick_on_q <= kick_on_d;
      kick_out_q <= kick_on_d ? kpct_d : '0;
      at_full_q <= (phase_d == ST_FULL);
    end
  end

  property p_speed_full;
    @(posedge clk) disable iff (reset)
      (starting && full_speed && !stop_req)
        |=> (phase_q == ST_FULL) && (volt_pct_q == FULL_PCT);
  endproperty
  a_speed_full: assert property (p_speed_full) else $error("no full at speed");

  property p_ramp_end;
    @(posedge clk) disable iff (reset)
      (phase_q == ST_RAMP && ramp_last && !stop_req) |=> at_full_q && (volt_pct_q == FULL_PCT);
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("ramp did not end at full");

  property p_ramp_begin;
    @(posedge clk) disable iff (reset)
      ($changed(phase_q) && phase_q == ST_RAMP && mode_q == MODE_SOFT) |-> (volt_pct_q == init_q);
  endproperty
  a_ramp_begin: assert property (p_ramp_begin) else $error("ramp not at initial level");

  property p_cl_hold;
    @(posedge clk) disable iff (reset)
      (phase_q == ST_RAMP && mode_q == MODE_CLIMIT) |-> climit_on_q && (climit_out_q == cl_q)
        && (cl_q <= CL_MAX_PCT);
  endproperty
  a_cl_hold: assert property (p_cl_hold) else $error("current limit level wrong");

  property p_kick_first;
    @(posedge clk) disable iff (reset)
      (accept && kick_c != '0) |=> kick_on_q && (kick_out_q == kpct_q) && (phase_q == ST_KICK);
  endproperty
  a_kick_first: assert property (p_kick_first) else $error("kick not applied");

  property p_profile_sel;
    @(posedge clk) disable iff (reset)
      accept |=> (profile2_q == $past(dual_ramp_en && dual_sel_in))
        && (init_q == $past(init_c));
  endproperty
  a_profile_sel: assert property (p_profile_sel) else $error("wrong profile");

  property p_frozen;
    @(posedge clk) disable iff (reset)
      (phase_q != ST_IDLE && $past(phase_q) != ST_IDLE) |-> $stable(ramp_ticks_q)
        && $stable(init_q) && $stable(mode_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("settings changed mid start");

  property p_monotonic;
    @(posedge clk) disable iff (reset)
      (phase_q == ST_RAMP && $past(phase_q) == ST_RAMP && mode_q == MODE_SOFT)
        |-> (volt_pct_q >= $past(volt_pct_q)) && (volt_pct_q < FULL_PCT);
  endproperty
  a_monotonic: assert property (p_monotonic) else $error("soft ramp not rising");

  property p_full_state;
    @(posedge clk) disable iff (reset)
      (phase_q == ST_FULL) |-> (volt_pct_q == FULL_PCT) && !climit_on_q && !kick_on_q;
  endproperty
  a_full_state: assert property (p_full_state) else $error("full phase wrong");
endmodule

//--- motor_start_pkg.sv
// constants and types shared by the motor start profile sequencer
// assumes a 100 MHz clock and a 10 ms timebase tick derived from it
package motor_start_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int TENTH_MS = 100;
  localparam int TICKS_PER_TENTH = TENTH_MS / TICK_MS;

  localparam int TENTHS_W = 9;
  localparam int TICKS_W = 12;
  localparam int PCT_W = 7;
  localparam int CL_W = 10;

  // settings in tenths of a second and in percent
  localparam logic [TENTHS_W-1:0] RAMP_MAX_TENTHS = 9'h12C;
  localparam logic [TENTHS_W-1:0] KICK_MAX_TENTHS = 9'h014;
  localparam logic [PCT_W-1:0] INIT_MAX_PCT = 7'h5A;
  localparam logic [PCT_W-1:0] KICK_MAX_PCT = 7'h5A;
  localparam logic [CL_W-1:0] CL_MAX_PCT = 10'h258;
  localparam logic [PCT_W-1:0] FULL_PCT = 7'h64;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_KICK = 2'b01,
    ST_RAMP = 2'b11,
    ST_FULL = 2'b10
  } phase_t;

  typedef enum logic {
    MODE_SOFT = 1'b0,
    MODE_CLIMIT = 1'b1
  } start_mode_t;
endpackage

//--- start_tick_gen.sv
// timebase tick generator for the start sequencer
// assumes restart is a one-cycle pulse that realigns the tick phase
`timescale 1ns/1ps
module start_tick_gen #(
  parameter int CYCLES = motor_start_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic restart,
  // one-cycle tick
  output logic tick
);
  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;
  wire wrap = (cnt_q == LAST);

  always_ff @(posedge clk) begin
    if (reset || restart || wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || restart) begin
      tick <= 1'b0;
    end else begin
      tick <= wrap;
    end
  end
endmodule

//--- motor_model.sv
// behavioural motor: reports full speed a set number of cycles after a start begins
// assumes phase_q of the sequencer; an accel of zero means it never gets up to speed
`timescale 1ns/1ps
module motor_model
  import motor_start_pkg::*;
(
  // clock
  input wire logic clk,
  // sequencer side
  input wire motor_start_pkg::phase_t phase_q,
  input wire logic [15:0] accel,
  // speed sensing
  output logic full_speed
);
  logic [15:0] cnt_q = 16'h0000;
  initial full_speed = 1'b0;
  always @(negedge clk) begin
    cnt_q <= (phase_q == ST_IDLE) ? 16'h0000 : cnt_q + 16'h0001;
    full_speed <= (phase_q != ST_IDLE) && (accel != 16'h0000)
      && (cnt_q + 16'h0001 >= accel);
  end
endmodule

//--- testbench.sv
// self-checking bench for the start sequencer, motor model on the speed input
// assumes a short tick of TC cycles; settings change at falling edges
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value at %0t: %s", $time, msg); \
    end \
  end
module testbench;
  import motor_start_pkg::*;
  localparam int TC = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic full_speed;
  logic dual_ramp_en = 1'b0;
  logic dual_sel_in = 1'b0;
  start_mode_t mode1 = MODE_SOFT;
  start_mode_t mode2 = MODE_SOFT;
  logic [TENTHS_W-1:0] ramp1_tenths = 9'h000, ramp2_tenths = 9'h000, kick_tenths = 9'h000;
  logic [PCT_W-1:0] init1_pct = 7'h00, init2_pct = 7'h00, kick_pct = 7'h00;
  logic [CL_W-1:0] climit_pct = 10'h000;
  phase_t phase_q;
  logic [PCT_W-1:0] volt_pct_q, kick_out_q;
  logic [CL_W-1:0] climit_out_q;
  logic climit_on_q, kick_on_q, profile2_q, at_full_q, cl, p2;
  logic [15:0] accel = 16'h0000;
  logic [31:0] rng = 32'h00000046;
  logic [31:0] r;
  int error_cnt = 0, total_checks = 0, cycles = 0, kt, nt, ini, klv, clv, fsk;
  always #5 clk = ~clk;
  motor_start_profile_sequencer #(.TICK_CYCLES(TC)) u_dut (.clk(clk), .reset(reset),
    .start_req(start_req), .stop_req(stop_req), .full_speed(full_speed),
    .dual_ramp_en(dual_ramp_en), .dual_sel_in(dual_sel_in), .mode1(mode1),
    .ramp1_tenths(ramp1_tenths), .init1_pct(init1_pct), .mode2(mode2),
    .ramp2_tenths(ramp2_tenths), .init2_pct(init2_pct), .climit_pct(climit_pct),
    .kick_tenths(kick_tenths), .kick_pct(kick_pct), .phase_q(phase_q),
    .volt_pct_q(volt_pct_q), .climit_on_q(climit_on_q), .climit_out_q(climit_out_q),
    .kick_on_q(kick_on_q), .kick_out_q(kick_out_q), .profile2_q(profile2_q),
    .at_full_q(at_full_q));
  motor_model u_motor (.clk(clk), .phase_q(phase_q), .accel(accel), .full_speed(full_speed));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic int lim(int v, int m);
    return v > m ? m : v;
  endfunction
  function automatic phase_t ephase(int k);
    if (fsk != 0 && k >= fsk) return ST_FULL;
    if (k < kt) return ST_KICK;
    if (k < kt + nt) return ST_RAMP;
    return ST_FULL;
  endfunction
  function automatic logic [PCT_W-1:0] evolt(int k);
    if (ephase(k) == ST_FULL) return FULL_PCT;
    if (cl) return 7'h00;
    if (k < kt) return PCT_W'(ini);
    return PCT_W'(ini + (int'(FULL_PCT) - ini) * (k - kt) / nt);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run(input logic [8:0] rp, kk, input logic [6:0] ip, kp, input logic [9:0] cp,
      input logic m, de, ds, input int fs);
    phase_t ph;
    @(negedge clk);
    r = rnd();
    p2 = de & ds;
    mode1 = start_mode_t'(p2 ? r[0] : m);
    mode2 = start_mode_t'(p2 ? m : r[0]);
    ramp1_tenths = p2 ? r[9:1] : rp;
    ramp2_tenths = p2 ? rp : r[9:1];
    init1_pct = p2 ? r[16:10] : ip;
    init2_pct = p2 ? ip : r[16:10];
    {kick_tenths, kick_pct, climit_pct, dual_ramp_en, dual_sel_in} = {kk, kp, cp, de, ds};
    fsk = fs;
    accel = 16'(fs * TC);
    kt = lim(kk, KICK_MAX_TENTHS) * TICKS_PER_TENTH;
    nt = lim(rp, RAMP_MAX_TENTHS) * TICKS_PER_TENTH;
    ini = lim(ip, INIT_MAX_PCT);
    klv = lim(kp, KICK_MAX_PCT);
    clv = lim(cp, CL_MAX_PCT);
    cl = m;
    start_req = 1'b1;
    @(negedge clk);
    // settings moved after the accept edge must not disturb this start
    r = rnd();
    {ramp1_tenths, ramp2_tenths, init1_pct} = r[24:0];
    mode1 = start_mode_t'(r[25]);
    mode2 = start_mode_t'(r[26]);
    r = rnd();
    {init2_pct, kick_pct, kick_tenths, dual_sel_in, dual_ramp_en} = r[24:0];
    climit_pct = r[31:22];
    repeat (5) @(negedge clk);
    for (int k = 0; k <= ((fs != 0) ? fs : kt + nt + 1); k++) begin
      if (k > 0) repeat (TC) @(negedge clk);
      ph = ephase(k);
      `CHK(phase_q, ph, "phase")
      `CHK(volt_pct_q, evolt(k), "voltage")
      `CHK(climit_on_q, cl && ph != ST_FULL, "limit on")
      `CHK(climit_out_q, (cl && ph != ST_FULL) ? CL_W'(clv) : 10'h000, "limit level")
      `CHK(kick_on_q, ph == ST_KICK, "kick on")
      `CHK(kick_out_q, (ph == ST_KICK) ? PCT_W'(klv) : 7'h00, "kick level")
      `CHK(at_full_q, ph == ST_FULL, "at full")
      `CHK(profile2_q, p2, "profile")
    end
    stop_req = 1'b1;
    @(negedge clk);
    stop_req = 1'b0;
    start_req = 1'b0;
    `CHK(phase_q, ST_IDLE, "stop phase")
    `CHK(volt_pct_q, 7'h00, "stop voltage")
    $display("test done at %0t", $time);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      $display("wrong value at %0t: run too long", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    run(9'h001, 9'h000, 7'h32, 7'h00, 10'h000, 1'b0, 1'b0, 1'b0, 0);
    run(9'h000, 9'h000, 7'h10, 7'h20, 10'h100, 1'b0, 1'b0, 1'b0, 0);
    run(9'h002, 9'h001, 7'h14, 7'h7F, 10'h3FF, 1'b1, 1'b1, 1'b1, 0);
    run(9'h003, 9'h000, 7'h7F, 7'h00, 10'h032, 1'b0, 1'b1, 1'b0, 12);
    run(9'h003, 9'h001, 7'h00, 7'h5A, 10'h258, 1'b1, 1'b0, 1'b1, 15);
    run(9'h002, 9'h001, 7'h28, 7'h40, 10'h190, 1'b0, 1'b1, 1'b1, 5);
    run(9'h1FF, 9'h1FF, 7'h5A, 7'h5B, 10'h259, 1'b0, 1'b0, 1'b0, 0);
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      run({7'h00, r[1:0]}, {8'h00, r[2]}, r[9:3], r[16:10], r[26:17], r[27], r[28], r[29],
        r[30] ? 7 : 0);
    end
    // stop in mid kick, then a start held under stop must be refused
    @(negedge clk);
    {kick_tenths, kick_pct, climit_pct, dual_ramp_en} = {9'h001, 7'h30, 10'h064, 1'b0};
    mode1 = MODE_CLIMIT;
    start_req = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(kick_on_q, 1'b1, "kick before stop")
    stop_req = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(phase_q, ST_IDLE, "start under stop")
    `CHK(kick_on_q, 1'b0, "kick after stop")
    `CHK(climit_on_q, 1'b0, "limit after stop")
    stop_req = 1'b0;
    start_req = 1'b0;
    $display("test done at %0t", $time);
    wrap_up();
  end
endmodule
